// >>> verilog/rtw_pkg.sv
// constants and types shared by the raw record write checker
package rtw_pkg;

    // ************************************************************
    // record limits and layout
    // ************************************************************
    localparam int          CNT_W     = 10;
    localparam int          ADDR_W    = 9;
    localparam int          ENT_W     = 2;
    localparam int          IDX_W     = 3;
    localparam int          NUM_RECS  = 4;                 // stored keys
    localparam int          NUM_BUFS  = NUM_RECS + 1;      // one spare for staging
    localparam int          MAX_DEPTH = 512;
    localparam logic [CNT_W-1:0] MIN_OCT   = 10'h00C;     // 12 octets
    localparam logic [CNT_W-1:0] MAX_OCT   = 10'h200;     // 512 octets
    localparam logic [CNT_W-1:0] LEN_OCT   = 10'h004;     // length field octets
    localparam logic [CNT_W-1:0] CLASS_IDX = 10'h007;     // access code class octet
    localparam logic [CNT_W-1:0] CNT_ZERO  = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ONE   = 10'h001;
    localparam logic [15:0]      SUM_ZERO  = 16'h0000;
    localparam logic [31:0]      LEN_ZERO  = 32'h0000_0000;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic [15:0] chan;
        logic [7:0]  teds_type;
    } rtw_key_s;

    typedef struct packed {
        logic ok;
        logic bad_count;
        logic bad_len;
        logic bad_sum;
        logic bad_type;
        logic full;
    } rtw_stat_s;

    typedef struct packed {
        logic             hit;
        logic [ENT_W-1:0] idx;
    } rtw_find_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RECV  = 2'b01,
        ST_CHECK = 2'b10,
        ST_DONE  = 2'b11
    } rtw_state_e;

endpackage

// >>> verilog/rtw_checker.sv
// running length, class and checksum capture over a received raw record
`timescale 1ns/1ns
module rtw_checker
    import rtw_pkg::*;
(
    input  wire logic             ref_clk_i,
    input  wire logic             rst_i,
    input  wire logic             clear_i,
    input  wire logic             oct_stb_i,
    input  wire logic [7:0]       oct_i,
    output logic      [CNT_W-1:0] cnt_o,
    output logic      [31:0]      len_o,
    output logic      [7:0]       cls_o,
    output logic      [15:0]      calc_sum_o,
    output logic      [15:0]      rx_sum_o
);

    logic [15:0] sum_all;
    logic [7:0]  last1;   // most recent octet
    logic [7:0]  last2;   // octet before it
    logic [15:0] data_sum;

    // ************************************************************
    // capture per octet
    // ************************************************************
    // count saturates one past the limit so an overlong record stays flagged
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || clear_i) begin
            cnt_o   <= CNT_ZERO;
            len_o   <= LEN_ZERO;
            cls_o   <= 8'h00;
            sum_all <= SUM_ZERO;
            last1   <= 8'h00;
            last2   <= 8'h00;
        end else if (oct_stb_i) begin
            if (cnt_o <= MAX_OCT)
                cnt_o <= cnt_o + CNT_ONE;
            if (cnt_o < LEN_OCT)
                len_o <= {len_o[23:0], oct_i};
            if (cnt_o == CLASS_IDX)
                cls_o <= oct_i;
            sum_all <= sum_all + {8'h00, oct_i};
            last2   <= last1;
            last1   <= oct_i;
        end
    end

    // ************************************************************
    // checksum views
    // ************************************************************
    // sum excludes the two trailing checksum octets
    assign data_sum   = sum_all - {8'h00, last1} - {8'h00, last2};
    assign calc_sum_o = ~data_sum;
    // checksum is the final two octets
    assign rx_sum_o   = {last2, last1};

    property p_class_cap;
        @(posedge ref_clk_i) disable iff (rst_i)
        (oct_stb_i && !clear_i && cnt_o == CLASS_IDX) |=> (cls_o == $past(oct_i));
    endproperty
    a_class_cap: assert property (p_class_cap) else $error("class octet not captured");

    property p_len_msb;
        @(posedge ref_clk_i) disable iff (rst_i)
        (oct_stb_i && !clear_i && cnt_o == CNT_ZERO) ##1 (oct_stb_i && !clear_i)[*3]
            |=> (len_o[31:24] == $past(oct_i, 4));
    endproperty
    a_len_msb: assert property (p_len_msb) else $error("length field not msb first");

endmodule

// >>> verilog/rtw_write_checker.sv
// raw record write interpreter: validates a record, then stores it by key
// Function
// - records are keyed by channel id and type; lookup uses that pair
// - valid write to an existing key replaces its stored record
// - valid write to an unknown key stores a new entry while one is free, else refused as full
// - record must hold 12 to 512 octets, else refused
// - record is length field, data block, checksum, parsed in order
// - length field must equal octets received after it
// - own checksum must equal the carried checksum
// - requested type must equal the header class octet
// - any failed check leaves stored records unchanged
`timescale 1ns/1ns
module rtw_write_checker
    import rtw_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic              req_valid_i,
    input  wire rtw_key_s          req_key_i,
    output logic                   req_ready_o,
    input  wire logic              oct_valid_i,
    input  wire logic [7:0]        oct_data_i,
    input  wire logic              oct_last_i,
    output logic                   oct_ready_o,
    output logic                   done_o,
    output rtw_stat_s              stat_o,
    input  wire rtw_key_s          rd_key_i,
    input  wire logic [ADDR_W-1:0] rd_addr_i,
    output logic                   rd_hit_o,
    output logic      [CNT_W-1:0]  rd_len_o,
    output logic      [7:0]        rd_data_o
);

    rtw_state_e                  state;
    rtw_state_e                  next_state;
    rtw_key_s                    key;
    logic [NUM_RECS-1:0]         ent_vld;
    rtw_key_s [NUM_RECS-1:0]     ent_key;
    logic [IDX_W-1:0]            ent_buf [NUM_RECS];
    logic [CNT_W-1:0]            ent_cnt [NUM_RECS];
    logic [IDX_W-1:0]            stg;
    logic [7:0]                  mem [NUM_BUFS][MAX_DEPTH];
    logic [CNT_W-1:0]            cnt;
    logic [31:0]                 len_field;
    logic [7:0]                  cls;
    logic [15:0]                 calc_sum;
    logic [15:0]                 rx_sum;
    logic                        oct_stb;
    logic                        wr_en;
    logic                        clear;
    logic                        bad_count;
    logic                        bad_len;
    logic                        bad_sum;
    logic                        bad_type;
    logic                        full;
    logic                        pass;
    logic                        commit;
    rtw_find_s                   look;
    rtw_find_s                   free;
    rtw_find_s                   rd_look;
    logic [ENT_W-1:0]            tgt;

    // ************************************************************
    // key search, shared by write lookup, free slot and read port
    // ************************************************************
    function automatic rtw_find_s rtw_find(input rtw_key_s               k,
                                           input logic [NUM_RECS-1:0]     vld,
                                           input rtw_key_s [NUM_RECS-1:0] keys,
                                           input logic                    want_free);
        rtw_find_s r;
        r = '0;
        for (int i = NUM_RECS - 1; i >= 0; i--) begin
            if (want_free ? !vld[i] : (vld[i] && keys[i] == k)) begin
                r.hit = 1'b1;
                r.idx = ENT_W'(i);
            end
        end
        return r;
    endfunction

    // ************************************************************
    // handshakes and decode
    // ************************************************************
    assign req_ready_o = (state == ST_IDLE);
    assign oct_ready_o = (state == ST_RECV);
    assign done_o      = (state == ST_DONE);
    assign clear       = req_ready_o && req_valid_i;
    assign oct_stb     = oct_ready_o && oct_valid_i;
    // octets past the limit are consumed but never written
    assign wr_en       = oct_stb && (cnt < MAX_OCT);

    // locate the record by channel and type
    assign look    = rtw_find(key, ent_vld, ent_key, 1'b0);
    assign free    = rtw_find(key, ent_vld, ent_key, 1'b1);
    assign rd_look = rtw_find(rd_key_i, ent_vld, ent_key, 1'b0);

    assign bad_count = (cnt < MIN_OCT) || (cnt > MAX_OCT);
    // length field against octets after it
    // a record shorter than the length field itself can never match
    assign bad_len   = (cnt < LEN_OCT) || (len_field != {22'h00_0000, cnt - LEN_OCT});
    assign bad_sum   = (calc_sum != rx_sum);
    assign bad_type  = (cls != key.teds_type);
    assign full      = !look.hit && !free.hit;
    assign pass      = !(bad_count || bad_len || bad_sum || bad_type || full);
    // only a clean record is committed
    assign commit    = (state == ST_CHECK) && pass;
    // overwrite on hit, else new entry
    assign tgt       = look.hit ? look.idx : free.idx;

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:  if (req_valid_i) next_state = ST_RECV;
            ST_RECV:  if (oct_stb && oct_last_i) next_state = ST_CHECK;
            ST_CHECK: next_state = ST_DONE;
            default:  next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            key   <= '0;
        end else begin
            state <= next_state;
            if (clear)
                key <= req_key_i;
        end
    end

    // octets are parsed in arrival order
    rtw_checker u_checker (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (rst_i),
        .clear_i    (clear),
        .oct_stb_i  (oct_stb),
        .oct_i      (oct_data_i),
        .cnt_o      (cnt),
        .len_o      (len_field),
        .cls_o      (cls),
        .calc_sum_o (calc_sum),
        .rx_sum_o   (rx_sum)
    );

    // ************************************************************
    // record storage
    // ************************************************************
    // staging goes to the spare buffer; commit swaps buffer ownership,
    // so a refused record never touches any stored entry and no copy is needed
    always_ff @(posedge ref_clk_i) begin
        if (wr_en)
            mem[stg][cnt[ADDR_W-1:0]] <= oct_data_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ent_vld <= '0;
            ent_key <= '0;
            stg     <= IDX_W'(NUM_BUFS - 1);
            for (int i = 0; i < NUM_RECS; i++) begin
                ent_buf[i] <= IDX_W'(i);
                ent_cnt[i] <= CNT_ZERO;
            end
        end else if (commit) begin
            ent_vld[tgt] <= 1'b1;
            ent_key[tgt] <= key;
            ent_buf[tgt] <= stg;
            ent_cnt[tgt] <= cnt;
            stg          <= ent_buf[tgt];
        end
    end

    // result and read port registers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            stat_o    <= '0;
            rd_hit_o  <= 1'b0;
            rd_len_o  <= CNT_ZERO;
            rd_data_o <= 8'h00;
        end else begin
            if (state == ST_CHECK)
                stat_o <= '{pass, bad_count, bad_len, bad_sum, bad_type, full};
            rd_hit_o  <= rd_look.hit;
            rd_len_o  <= rd_look.hit ? ent_cnt[rd_look.idx] : CNT_ZERO;
            rd_data_o <= mem[ent_buf[rd_look.idx]][rd_addr_i];
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_commit;
        (state == ST_CHECK) && pass;
    endsequence

    sequence s_refuse;
        (state == ST_CHECK) && !pass;
    endsequence

    property p_key_found;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_commit |=> (look.hit && ent_buf[look.idx] == $past(stg));
    endproperty
    a_key_found: assert property (p_key_found) else $error("committed record not found by key");

    property p_overwrite;
        @(posedge ref_clk_i) disable iff (rst_i)
        (s_commit and look.hit) |=> ($countones(ent_vld) == $countones($past(ent_vld)));
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("overwrite changed entry count");

    property p_add_new;
        @(posedge ref_clk_i) disable iff (rst_i)
        (s_commit and !look.hit) |=> ($countones(ent_vld) == $countones($past(ent_vld)) + 1);
    endproperty
    a_add_new: assert property (p_add_new) else $error("new record not added");

    property p_count_range;
        @(posedge ref_clk_i) disable iff (rst_i)
        (state == ST_CHECK && (cnt < MIN_OCT || cnt > MAX_OCT)) |-> !commit ##1 !stat_o.ok;
    endproperty
    a_count_range: assert property (p_count_range) else $error("bad octet count accepted");

    property p_len_match;
        @(posedge ref_clk_i) disable iff (rst_i)
        (state == ST_CHECK && len_field + 32'h0000_0004 != {22'h00_0000, cnt}) |=> stat_o.bad_len;
    endproperty
    a_len_match: assert property (p_len_match) else $error("length mismatch not flagged");

    property p_sum_match;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_commit |-> (rx_sum == calc_sum);
    endproperty
    a_sum_match: assert property (p_sum_match) else $error("record stored with bad checksum");

    property p_type_match;
        @(posedge ref_clk_i) disable iff (rst_i)
        (state == ST_CHECK && cls != key.teds_type) |=> (stat_o.bad_type && !stat_o.ok && done_o);
    endproperty
    a_type_match: assert property (p_type_match) else $error("type mismatch not refused");

    property p_no_change;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_refuse |=> ($stable(ent_vld) && $stable(ent_key) && $stable(stg));
    endproperty
    a_no_change: assert property (p_no_change) else $error("refused record changed storage");

endmodule

// >>> testbench/rtw_requester.sv
// requester model: raises a write request and streams the record octets
`timescale 1ns/1ns
module rtw_requester
    import rtw_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       req_ready_i,
    input  wire logic       oct_ready_i,
    input  wire logic [7:0] rec_i [0:MAX_DEPTH],
    output logic            req_valid_o,
    output rtw_key_s        req_key_o,
    output logic            oct_valid_o,
    output logic [7:0]      oct_data_o,
    output logic            oct_last_o
);
    // quiet lines before the first request
    initial begin
        req_valid_o = 1'b0;
        req_key_o   = '0;
        oct_valid_o = 1'b0;
        oct_data_o  = 8'h00;
        oct_last_o  = 1'b0;
    end

    // binary octets in order
    // request held until taken; slow mode leaves a gap before some octets,
    // and released lines flip so a stale value never passes for fresh data
    task automatic send(input rtw_key_s key, input int n, input bit slow);
        int i;
        bit gap;
        i   = 0;
        gap = 1'b0;
        @(negedge ref_clk_i);
        req_valid_o = 1'b1;
        req_key_o   = key;
        do @(posedge ref_clk_i); while (req_ready_i !== 1'b1);
        while (i < n) begin
            @(negedge ref_clk_i);
            req_valid_o = 1'b0;
            req_key_o   = ~key;
            if (slow && !gap && i % 3 == 1) begin
                gap         = 1'b1;
                oct_valid_o = 1'b0;
                oct_data_o  = ~oct_data_o;
            end else begin
                gap         = 1'b0;
                oct_valid_o = 1'b1;
                oct_data_o  = rec_i[i];
                oct_last_o  = (i == n - 1);
                @(posedge ref_clk_i);
                if (oct_ready_i === 1'b1) i++;
            end
        end
        @(negedge ref_clk_i);
        oct_valid_o = 1'b0;
        oct_last_o  = 1'b0;
        oct_data_o  = ~oct_data_o;
    endtask
endmodule

// >>> testbench/rtw_write_checker_tb_top.sv
// self-checking bench for the raw record write checker
`timescale 1ns/1ns
module rtw_write_checker_tb_top
    import rtw_pkg::*;
;
    // ****************************************************************
    // signals, design and requester
    // ****************************************************************
    logic              ref_clk_i   = 1'b0;
    logic              rst_i       = 1'b1;
    logic              req_valid, req_ready, oct_valid, oct_last, oct_ready, done, rd_hit;
    rtw_key_s          req_key;
    rtw_key_s          rd_key      = '0;
    logic [ADDR_W-1:0] rd_addr     = '0;
    logic [7:0]        oct_data, rd_data;
    logic [CNT_W-1:0]  rd_len;
    rtw_stat_s         stat;
    logic [7:0]        rec [0:MAX_DEPTH];
    logic [31:0]       seed        = 32'h682e_d330;
    int                miscompares = 0;
    int                check_count = 0;
    // shadow of the stored table; a zero count marks a free entry
    rtw_key_s          sk [NUM_RECS];
    int                sn [NUM_RECS] = '{default: 0};
    logic [7:0]        sd [NUM_RECS][MAX_DEPTH];
    // corner records: count limits, meta record, single flaws, fill, full, overwrite
    int                cn [10] = '{11, 513, 512, 12, 20, 20, 20, 14, 16, 30};
    int                cf [10] = '{0, 0, 0, 0, 1, 2, 0, 0, 0, 0};
    logic [7:0]        cc [10] = '{8'h01, 8'h01, 8'h01, 8'h03, 8'h05, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0C};
    logic [23:0]       ck [10] = '{24'h00_0101, 24'h00_0101, 24'h00_0001, 24'h00_0203, 24'h00_0505,
                                   24'h00_0505, 24'h00_0505, 24'h00_0307, 24'h00_0909, 24'h00_040C};
    logic [7:0]        ex [23] = '{8'h00, 8'h00, 8'h00, 8'h13, 8'h03, 8'h04, 8'h00, 8'h0C, 8'h01, 8'h01,
                                   8'h04, 8'h01, 8'h00, 8'h45, 8'h53, 8'h2D, 8'h54, 8'h49, 8'h4D, 8'h30,
                                   8'h34, 8'hFD, 8'hBF};

    always #5 ref_clk_i = ~ref_clk_i;

    rtw_write_checker i_rtw_write_checker (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .req_valid_i (req_valid),
        .req_key_i   (req_key),
        .req_ready_o (req_ready),
        .oct_valid_i (oct_valid),
        .oct_data_i  (oct_data),
        .oct_last_i  (oct_last),
        .oct_ready_o (oct_ready),
        .done_o      (done),
        .stat_o      (stat),
        .rd_key_i    (rd_key),
        .rd_addr_i   (rd_addr),
        .rd_hit_o    (rd_hit),
        .rd_len_o    (rd_len),
        .rd_data_o   (rd_data)
    );

    rtw_requester i_rtw_requester (
        .ref_clk_i   (ref_clk_i),
        .req_ready_i (req_ready),
        .oct_ready_i (oct_ready),
        .rec_i       (rec),
        .req_valid_o (req_valid),
        .req_key_o   (req_key),
        .oct_valid_o (oct_valid),
        .oct_data_o  (oct_data),
        .oct_last_o  (oct_last)
    );

    // ****************************************************************
    // helpers: random source, comparisons, record builder, transfers
    // ****************************************************************
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function int slot(input rtw_key_s k, input bit fr);
        for (int i = 0; i < NUM_RECS; i++) begin
            if (fr ? sn[i] == 0 : (sn[i] != 0 && sk[i] === k)) return i;
        end
        return -1;
    endfunction

    task tally_and_finish();
        if (miscompares == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task cmp_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task cmp_stat(input rtw_stat_s exp, input rtw_stat_s got, input rtw_stat_s mask);
        check_count++;
        if ((got & mask) !== (exp & mask)) begin
            miscompares++;
            $display("MISMATCH stat expected %b seen %b", exp & mask, got);
        end
    endtask

    // flaw 1 spoils the length field, flaw 2 the checksum
    task build(input int n, input logic [7:0] cls, input int flaw);
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < n; i++) rec[i] = 8'(rnd());
        {rec[0], rec[1], rec[2], rec[3]} = 32'(n - 4) + ((flaw == 1) ? 32'h0000_0001 : 32'h0000_0000);
        rec[7] = cls;
        for (int i = 0; i < n - 2; i++) s += 16'(rec[i]);
        {rec[n-2], rec[n-1]} = ~s ^ ((flaw == 2) ? 16'h0001 : 16'h0000);
    endtask

    // reads a whole stored record back, or one miss when absent
    task chk_key(input rtw_key_s k);
        int s;
        s = slot(k, 1'b0);
        for (int a = 0; a < ((s < 0) ? 1 : sn[s]); a++) begin
            @(negedge ref_clk_i);
            rd_key  = k;
            rd_addr = ADDR_W'(a);
            @(posedge ref_clk_i);
            #1;
            cmp_val("rd_hit", 16'(s >= 0), 16'(rd_hit));
            cmp_val("rd_len", 16'((s < 0) ? 0 : sn[s]), 16'(rd_len));
            if (s >= 0) cmp_val("rd_data", 16'(sd[s][a]), 16'(rd_data));
        end
    endtask

    task xfer(input rtw_key_s k, input int n, input bit slow);
        rtw_stat_s   e;
        rtw_stat_s   m;
        logic [15:0] s;
        int          h;
        int          f;
        int          w;
        s = 16'h0000;
        for (int i = 0; i < n - 2; i++) s += 16'(rec[i]);
        h = slot(k, 1'b0);
        f = slot(k, 1'b1);
        e.bad_count = (n < 12) || (n > 512);
        e.bad_len   = {rec[0], rec[1], rec[2], rec[3]} !== 32'(n - 4);
        e.bad_sum   = {rec[n-2], rec[n-1]} !== ~s;
        e.bad_type  = rec[7] !== k.teds_type;
        e.full      = (h < 0) && (f < 0);
        e.ok        = !(e.bad_count | e.bad_len | e.bad_sum | e.bad_type | e.full);
        // with a bad count the other causes are left open, likewise full beside a bad content check
        m = e.bad_count ? rtw_stat_s'(6'h30) : ((e.bad_len | e.bad_sum | e.bad_type) ? rtw_stat_s'(6'h3E)
                                                                                      : rtw_stat_s'(6'h3F));
        i_rtw_requester.send(k, n, slow);
        w = 0;
        do begin
            @(posedge ref_clk_i);
            #1;
            w++;
        end while (done !== 1'b1 && w < 9);
        cmp_val("done_latency", 16'h0001, 16'(w));
        cmp_stat(e, stat, m);
        if (e.ok) begin
            h = (h >= 0) ? h : f;
            sk[h] = k;
            sn[h] = n;
            for (int i = 0; i < n; i++) sd[h][i] = rec[i];
        end
        chk_key(k);
        for (int i = 0; i < NUM_RECS; i++) if (sn[i] != 0 && sk[i] !== k) chk_key(sk[i]);
    endtask

    // watchdog well beyond the expected run length
    initial begin
        #1_000_000;
        miscompares++;
        tally_and_finish();
    end

    // main sequence: worked record, corner table, then random traffic
    initial begin
        logic [31:0] r;
        int          c;
        int          fl;
        repeat (4) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_i = 1'b0;
        chk_key(24'h00_040C);
        for (int i = 0; i < 23; i++) rec[i] = ex[i];
        xfer(24'h00_040C, 23, 1'b0);
        for (int j = 0; j < 10; j++) begin
            build(cn[j], cc[j], cf[j]);
            xfer(ck[j], cn[j], j[0]);
        end
        for (int j = 0; j < 30; j++) begin
            r  = rnd();
            c  = int'(r[7:0]) % 6;
            fl = int'(r[18:16]) % 5;
            build(12 + int'(r[15:8]) % 40, (fl == 3) ? 8'(c + 2) : 8'(c + 1), fl);
            xfer({16'(c), 8'(c + 1)}, 12 + int'(r[15:8]) % 40, r[20]);
        end
        tally_and_finish();
    end
endmodule
